// ---- design/asrc_ctrl.sv ----
`timescale 1ns/1ps
module asrc_ctrl
  import asrc_pkg::*;
#(
  parameter int SETUP_N = SETUP_CYC,  // cycles selected before the write strobe
  parameter int PULSE_N = PULSE_CYC,  // write strobe width in cycles
  parameter int READ_N  = READ_CYC,   // cycles selected for a read
  parameter int HOLD_N  = HOLD_CYC    // cycles held after the strobe rises
)(
  input  wire logic              clk,           // 100 MHz clock
  input  wire logic              resetn,        // async reset, active low
  input  wire logic              req_valid,     // request present
  input  wire asrc_req_t         req,           // request
  output logic                   req_ready,     // idle, request accepted
  output logic                   rsp_valid,     // read data pulse
  output logic      [DATA_W-1:0] rsp_data,      // read data
  output asrc_pins_t             pins,          // memory control and address
  output logic      [DATA_W-1:0] data_pins_o,   // data out
  output logic                   data_pins_oe,  // data drive enable
  input  wire logic [DATA_W-1:0] data_pins_i    // data in
);
  // =======================================================
  // parameter checks
  if (SETUP_N < 1)
  begin
    $error("asrc_ctrl: SETUP_N must be at least 1");
  end
  if (PULSE_N < 1)
  begin
    $error("asrc_ctrl: PULSE_N must be at least 1");
  end
  if (HOLD_N < 1)
  begin
    $error("asrc_ctrl: HOLD_N must be at least 1");
  end
  // two cycles are lost in the input synchroniser
  if (READ_N < 3)
  begin
    $error("asrc_ctrl: READ_N must be at least 3");
  end
  if (SETUP_N > (1 << CNT_W) || PULSE_N > (1 << CNT_W) ||
      READ_N > (1 << CNT_W) || HOLD_N > (1 << CNT_W))
  begin
    $error("asrc_ctrl: phase count does not fit the counter");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_WSET, ST_WPULSE, ST_WHOLD} asrc_state_t;

  // =======================================================
  // data input synchroniser
  logic [DATA_W-1:0] din_s;
  asrc_sync #(.W(DATA_W)) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      (data_pins_i),
    .q      (din_s)
  );

  // =======================================================
  // state
  asrc_state_t        state_r, state_nxt;
  logic [CNT_W-1:0]   cnt_r, cnt_nxt;
  asrc_pins_t         pins_nxt;
  logic [DATA_W-1:0]  dout_nxt;
  logic               oe_nxt, rdy_nxt, rv_nxt;
  logic [DATA_W-1:0]  rdat_nxt;
  wire                take    = req_ready && req_valid;
  wire                cnt_end = (cnt_r == '0);
  wire [CNT_W-1:0]    cnt_dec = cnt_r - CNT_W'(1);

  // =======================================================
  // counter loads for each phase
  wire [CNT_W-1:0]    setup_load = CNT_W'(SETUP_N - 1);
  wire [CNT_W-1:0]    pulse_load = CNT_W'(PULSE_N - 1);
  wire [CNT_W-1:0]    read_load  = CNT_W'(READ_N - 1);
  wire [CNT_W-1:0]    hold_load  = CNT_W'(HOLD_N - 1);

  function automatic asrc_pins_t idle_pins(input logic [ADDR_W-1:0] a);
    idle_pins = '{chip_select_low_n: 1'b1, chip_select_high: 1'b0,
                  output_gate_n: 1'b1, write_strobe_n: 1'b1, addr: a};
  endfunction

  // =======================================================
  // next state
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_end ? cnt_r : cnt_dec;
    pins_nxt  = pins;
    dout_nxt  = data_pins_o;
    oe_nxt    = data_pins_oe;
    rdy_nxt   = req_ready;
    rv_nxt    = 1'b0;
    rdat_nxt  = rsp_data;
    unique case (state_r)
      ST_IDLE:
      begin
        if (take)
        begin
          // address loaded on the same edge that both selects go active
          pins_nxt = idle_pins(req.addr);
          rdy_nxt  = 1'b0;
          dout_nxt = req.wdata;
          if (req.write)
          begin
            // select without gate, so device outputs stay off before drive
            pins_nxt.chip_select_low_n = 1'b0;
            pins_nxt.chip_select_high  = 1'b1;
            cnt_nxt   = setup_load;
            state_nxt = ST_WSET;
          end
          else
          begin
            pins_nxt.chip_select_low_n = 1'b0;
            pins_nxt.chip_select_high  = 1'b1;
            pins_nxt.output_gate_n     = 1'b0;
            cnt_nxt   = read_load;
            state_nxt = ST_RD;
          end
        end
      end
      ST_RD:
      begin
        if (cnt_end)
        begin
          // sampled data is two cycles late through the synchroniser
          rdat_nxt  = din_s;
          rv_nxt    = 1'b1;
          pins_nxt  = idle_pins(pins.addr);
          rdy_nxt   = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      ST_WSET:
      begin
        if (cnt_end)
        begin
          // strobe low with both selects active starts the write
          pins_nxt.write_strobe_n = 1'b0;
          oe_nxt    = 1'b1;
          cnt_nxt   = pulse_load;
          state_nxt = ST_WPULSE;
        end
      end
      ST_WPULSE:
      begin
        if (cnt_end)
        begin
          // strobe rise stores the byte; data and address held past it
          pins_nxt.write_strobe_n = 1'b1;
          cnt_nxt   = hold_load;
          state_nxt = ST_WHOLD;
        end
      end
      ST_WHOLD:
      begin
        if (cnt_end)
        begin
          oe_nxt    = 1'b0;
          // gate kept high so the device does not drive back
          pins_nxt  = idle_pins(pins.addr);
          rdy_nxt   = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // =======================================================
  // registers
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end

  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      pins         <= '{chip_select_low_n: 1'b1, chip_select_high: 1'b0,
                        output_gate_n: 1'b1, write_strobe_n: 1'b1, addr: '0};
      data_pins_o  <= '0;
      data_pins_oe <= 1'b0;
    end
    else
    begin
      pins         <= pins_nxt;
      data_pins_o  <= dout_nxt;
      data_pins_oe <= oe_nxt;
    end

  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      req_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
    end
    else
    begin
      req_ready <= rdy_nxt;
      rsp_valid <= rv_nxt;
      rsp_data  <= rdat_nxt;
    end
endmodule

// ---- design/asrc_pkg.sv ----
package asrc_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int WORDS  = 65536;
  // phase lengths in ns, rounded up to clock cycles (10 ns each)
  localparam int CLK_NS      = 10;
  localparam int T_SETUP_NS  = 10;
  localparam int T_PULSE_NS  = 20;
  localparam int T_READ_NS   = 40;
  localparam int T_HOLD_NS   = 10;
  localparam int SETUP_CYC   = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC   = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_CYC    = (T_READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC    = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W       = 4;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asrc_req_t;

  typedef struct packed {
    logic              chip_select_low_n;
    logic              chip_select_high;
    logic              output_gate_n;
    logic              write_strobe_n;
    logic [ADDR_W-1:0] addr;
  } asrc_pins_t;
endpackage

// ---- design/asrc_sync.sv ----
`timescale 1ns/1ps
module asrc_sync
  import asrc_pkg::*;
#(
  parameter int W = 8
)(
  input  wire logic         clk,     // clock
  input  wire logic         resetn,  // async reset
  input  wire logic [W-1:0] d,       // asynchronous input
  output logic      [W-1:0] q        // synchronised
);
  logic [W-1:0] s1_r;
  if (W < 1)
  begin
    $error("asrc_sync: W must be at least 1");
  end
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      s1_r <= '0;
      q    <= '0;
    end
    else
    begin
      s1_r <= d;
      q    <= s1_r;
    end
endmodule

// ---- tb/asrc_ctrl_chk.sv ----
`timescale 1ns/1ps
module asrc_ctrl_chk
  import asrc_pkg::*;
(
  input logic              clk,          // clock
  input logic              resetn,       // reset
  input logic              req_valid,    // request
  input asrc_req_t         req,          // request
  input logic              req_ready,    // idle
  input logic              rsp_valid,    // read done
  input asrc_pins_t        pins,         // strobes
  input logic [DATA_W-1:0] data_pins_o,  // write byte
  input logic              data_pins_oe  // host drives
);
  // ======
  // checks
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  wire sel = !pins.chip_select_low_n && pins.chip_select_high;
  AST_WR_SEL: assert property (!pins.write_strobe_n |-> sel && data_pins_oe)
    else $error("strobe low unselected");
  AST_NO_FIGHT: assert property (data_pins_oe |-> pins.output_gate_n)
    else $error("drive with gate open");
  AST_ADDR_HOLD: assert property (sel && $past(sel) |-> $stable(pins.addr))
    else $error("address moved");
  AST_RD_ADDR: assert property ($rose(sel) |-> pins.addr == $past(req.addr))
    else $error("address late");
  AST_STORE: assert property ($rose(pins.write_strobe_n) |-> sel && data_pins_oe)
    else $error("write end wrong");
  // answer registered one edge after the last of READ_CYC selected cycles
  AST_RD_LAT: assert property (req_valid && req_ready && !req.write |-> ##5 rsp_valid)
    else $error("read latency");
  cover property (rsp_valid);
  cover property ($rose(pins.write_strobe_n));
  cover property (req_valid && !req_ready);
endmodule
bind asrc_ctrl asrc_ctrl_chk u_chk (.clk, .resetn, .req_valid, .req, .req_ready,
  .rsp_valid, .pins, .data_pins_o, .data_pins_oe);

// ---- tb/asrc_sram_model.sv ----
`timescale 1ns/1ps
module asrc_sram_model
  import asrc_pkg::*;
(
  input  logic              clk,          // float pattern
  input  asrc_pins_t        pins,         // strobes
  input  logic [DATA_W-1:0] data_pins_o,  // host byte
  input  logic              data_pins_oe, // host drives
  output logic [DATA_W-1:0] data_pins_i   // bus level
);
  // ======
  // memory
  logic [DATA_W-1:0] mem_r [WORDS];
  logic [DATA_W-1:0] flt_r = 8'hA5;
  wire sel = !pins.chip_select_low_n && pins.chip_select_high;
  wire wr  = sel && !pins.write_strobe_n;
  wire rd  = sel && !pins.output_gate_n && pins.write_strobe_n;
  always @(posedge clk) flt_r <= ~flt_r;
  // only a real 1 to 0 change of the write condition stores, not x at start
  logic wr_d = 1'b0;
  always @(wr)
  begin
    if (wr === 1'b0 && wr_d)
      mem_r[pins.addr] = data_pins_i;
    wr_d = (wr === 1'b1);
  end
  assign data_pins_i = data_pins_oe ? (rd ? 'x : data_pins_o) : rd ? mem_r[pins.addr] : flt_r;
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
  import asrc_pkg::*;
;
  logic              clk;
  logic              resetn;
  logic              req_valid;
  asrc_req_t         req;
  logic              req_ready;
  logic              rsp_valid;
  logic [DATA_W-1:0] rsp_data;
  asrc_pins_t        pins;
  logic [DATA_W-1:0] data_pins_o;
  logic              data_pins_oe;
  logic [DATA_W-1:0] data_pins_i;
  int                n_fail = 0;
  int                total_checks = 0;
  wire [15:0]        wr_view = {6'h00, data_pins_oe, pins.write_strobe_n, data_pins_o};
  wire [15:0]        idle_view = {13'h0000, data_pins_oe, pins.chip_select_low_n,
                                  pins.chip_select_high};
  asrc_ctrl dut (.clk, .resetn, .req_valid, .req, .req_ready, .rsp_valid, .rsp_data,
    .pins, .data_pins_o, .data_pins_oe, .data_pins_i);
  asrc_sram_model u_mem (.clk, .pins, .data_pins_o, .data_pins_oe, .data_pins_i);
  // ======
  // tasks
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic go(logic w, logic [15:0] a, logic [7:0] d);
    @(negedge clk);
    req_valid = 1'b1;
    req = '{w, a, d};
    while (req_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  task automatic rd(logic [15:0] a, logic [7:0] d);
    go(1'b0, a, 8'h00);
    repeat (3) @(negedge clk);
    chk("rsp_early", 16'h0000, {15'h0000, rsp_valid});
    @(negedge clk);
    chk("rsp_valid", 16'h0001, {15'h0000, rsp_valid});
    chk("rsp_data", {8'h00, d}, {8'h00, rsp_data});
    @(negedge clk);
    chk("rsp_pulse", 16'h0000, {15'h0000, rsp_valid});
  endtask
  task automatic t_rw();
    go(1'b1, 16'h1234, 8'h5A);
    @(negedge clk);
    chk("wr_drive", 16'h025A, wr_view);
    rd(16'h1234, 8'h5A);
    $display("t_rw done");
  endtask
  task automatic t_bound();
    go(1'b1, 16'h0000, 8'hA5);
    go(1'b1, 16'hFFFF, 8'h3C);
    rd(16'h0000, 8'hA5);
    rd(16'hFFFF, 8'h3C);
    $display("t_bound done");
  endtask
  task automatic t_keep();
    go(1'b1, 16'h1234, 8'hC3);
    rd(16'h0000, 8'hA5);
    rd(16'h1234, 8'hC3);
    chk("idle", 16'h0002, idle_view);
    $display("t_keep done");
  endtask
  task automatic t_reset();
    go(1'b0, 16'h1234, 8'h00);
    @(negedge clk);
    resetn = 1'b0;
    @(negedge clk);
    chk("rst_ready", 16'h0001, {15'h0000, req_ready});
    chk("rst_addr", 16'h0000, pins.addr);
    chk("rst_idle", 16'h0002, idle_view);
    resetn = 1'b1;
    rd(16'h1234, 8'hC3);
    $display("t_reset done");
  endtask
  task automatic complete_run();
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ======
  // run
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    resetn = 1'b0;
    req_valid = 1'b0;
    req = '0;
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    t_rw();
    t_bound();
    t_keep();
    t_reset();
    complete_run();
  end
  initial
  begin
    repeat (2000) @(posedge clk);
    n_fail++;
    complete_run();
  end
endmodule
